// File: core/bapwm_pkg.sv
// package for the button adjusted pulse width generator: timing counts and carried types
// assumes one 125 MHz clock and a synchronous active-low reset in every user
//
// Summary of operation
// - output period repeats every ten clock cycles of the block clock
// - ten duty settings, 0% to 90% high time, in 10% steps
// - each lone debounced increase press adds one step up to 90%, each lone decrease press removes one down to 0%
// - both buttons pass flip-flop debounce stages before any action
// - a divider counter makes a slow enable; debounce shift stages sample only then
package bapwm_pkg;

	localparam int unsigned CLK_HZ        = 125_000_000;
	// debounce sample interval, in microseconds
	localparam int unsigned DEB_TICK_US   = 1000;
	localparam int unsigned DEB_TICK_CYC  = (CLK_HZ / 1_000_000) * DEB_TICK_US;
	localparam int unsigned DEB_CNT_W     = $clog2(DEB_TICK_CYC);

	localparam logic [3:0] PWM_PERIOD_CYC = 4'hA;
	localparam logic [3:0] PHASE_RST      = 4'h0;
	localparam logic [3:0] DUTY_MAX       = 4'h9;
	localparam logic [3:0] DUTY_RST       = 4'h0;

	typedef struct packed {
		logic inc;
		logic dec;
	} bapwm_btn_t;

endpackage

// File: core/bapwm_debounce_flop_stage.sv
// debounce_flop_stage: two-flop synchroniser then a three-sample shift stage
// assumes sample_en_i is a one-cycle enable from a divider on the same clock
module bapwm_debounce_flop_stage
	import bapwm_pkg::*;
(
	// clock and reset
	input  wire logic mclk_i,
	input  wire logic rst_n_i,
	// sampling
	input  wire logic sample_en_i,
	input  wire logic btn_i,
	// result
	output logic      press_o
);

	logic       sync1_q, sync1_d;
	logic       sync2_q, sync2_d;
	logic [2:0] shf_q, shf_d;
	logic       press_q, press_d;

	always_comb begin
		sync1_d = btn_i;
		sync2_d = sync1_q;
		shf_d   = shf_q;
		press_d = 1'b0;
		if (sample_en_i) begin
			shf_d   = {shf_q[1:0], sync2_q};
			// press on the second high sample in a row after a low, so bounce gives one step
			press_d = sync2_q & shf_q[0] & ~shf_q[1];
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			shf_q   <= 3'h0;
			press_q <= 1'b0;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			shf_q   <= shf_d;
			press_q <= press_d;
		end
	end

	assign press_o = press_q;

endmodule

// File: core/bapwm_top.sv
// button adjusted pulse width generator top level
// assumes buttons are raw asynchronous pins, high while pressed; one clock domain
module bapwm_top
	import bapwm_pkg::*;
#(
	parameter int unsigned DEB_TICK = DEB_TICK_CYC
) (
	// clock and reset
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	// user_input_bus buttons
	input  wire bapwm_btn_t user_input_bus_i,
	// outputs
	output logic            pwm_o,
	output logic [3:0]      duty_o
);

	// step request decoded from one cycle of press pulses
	typedef enum logic [1:0] {
		STEP_NONE,
		STEP_UP,
		STEP_DOWN
	} bapwm_step_t;

	localparam int unsigned NUM_BTN = $bits(bapwm_btn_t);

	logic [DEB_CNT_W-1:0] tick_q, tick_d;
	logic                 en_q, en_d;
	logic [3:0]           phase_q, phase_d;
	logic [3:0]           duty_q, duty_d;
	logic                 pwm_q, pwm_d;
	logic [NUM_BTN-1:0]   raw_vec;
	logic [NUM_BTN-1:0]   press_vec;
	bapwm_btn_t           press;
	bapwm_step_t          step;

	// both buttons in one sample cancel out rather than guess an order
	function automatic bapwm_step_t decode_step(input bapwm_btn_t p);
		bapwm_step_t s;
		s = STEP_NONE;
		if (p.inc && !p.dec) begin
			s = STEP_UP;
		end else if (p.dec && !p.inc) begin
			s = STEP_DOWN;
		end
		return s;
	endfunction

	// saturating one-step move of the duty setting
	function automatic logic [3:0] move_duty(input logic [3:0] d, input bapwm_step_t s);
		logic [3:0] r;
		r = d;
		unique case (s)
			STEP_UP: begin
				if (d != DUTY_MAX) begin
					r = d + 4'h1;
				end
			end
			STEP_DOWN: begin
				if (d != DUTY_RST) begin
					r = d - 4'h1;
				end
			end
			STEP_NONE: begin
				r = d;
			end
			default: begin
				r = d;
			end
		endcase
		return r;
	endfunction

	// phase after p, wrapping so one output period is PWM_PERIOD_CYC cycles
	function automatic logic [3:0] next_phase(input logic [3:0] p);
		logic [3:0] n;
		if (p == PWM_PERIOD_CYC - 4'h1) begin
			n = PHASE_RST;
		end else begin
			n = p + 4'h1;
		end
		return n;
	endfunction

	// slow enable divider; only the debounce stages use it
	always_comb begin
		tick_d = tick_q + 1'b1;
		en_d   = 1'b0;
		if (tick_q == DEB_CNT_W'(DEB_TICK - 1)) begin
			tick_d = '0;
			en_d   = 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			tick_q <= '0;
			en_q   <= 1'b0;
		end else begin
			tick_q <= tick_d;
			en_q   <= en_d;
		end
	end

	assign raw_vec = user_input_bus_i;

	// one identical stage per button, each with its own synchroniser
	for (genvar gi = 0; gi < NUM_BTN; gi++) begin : g_deb
		bapwm_debounce_flop_stage u_bapwm_debounce_flop_stage (
			.mclk_i      (mclk_i),
			.rst_n_i     (rst_n_i),
			.sample_en_i (en_q),
			.btn_i       (raw_vec[gi]),
			.press_o     (press_vec[gi])
		);
	end

	assign press = bapwm_btn_t'(press_vec);
	assign step  = decode_step(press);

	// duty setting moves only on a decoded press pulse
	always_comb begin
		duty_d = move_duty(duty_q, step);
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			duty_q <= DUTY_RST;
		end else begin
			duty_q <= duty_d;
		end
	end

	// free-running phase counter, one pass per output period
	always_comb begin
		phase_d = next_phase(phase_q);
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			phase_q <= PHASE_RST;
		end else begin
			phase_q <= phase_d;
		end
	end

	// compare against the coming phase so pwm_q lines up with phase_q;
	// a new setting takes effect at once, so one period may be cut short
	always_comb begin
		pwm_d = (phase_d < duty_q);
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			pwm_q <= 1'b0;
		end else begin
			pwm_q <= pwm_d;
		end
	end

	assign pwm_o  = pwm_q;
	assign duty_o = duty_q;

endmodule

// File: tb/bapwm_checker.sv
// port checker for the pwm top
// assumes a synchronous active-low reset
module bapwm_checker
	import bapwm_pkg::*;
(
	input wire logic       mclk_i,
	input wire logic       rst_n_i,
	input wire bapwm_btn_t user_input_bus_i,
	input wire logic       pwm_o,
	input wire logic [3:0] duty_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	// a setting that falls to zero just after a rise must not count as a lost period
	property p_per; $rose(pwm_o) && duty_o != 4'h0 ##1 $stable(duty_o)[*8] ##1 $stable(duty_o)
		|=> $rose(pwm_o); endproperty
	a_per: assert property (p_per) else $error("pwm period");
	property p_max; duty_o <= DUTY_MAX; endproperty
	a_max: assert property (p_max) else $error("duty range");
	property p_off; duty_o == 4'h0_000 |=> !pwm_o; endproperty
	a_off: assert property (p_off) else $error("pwm at zero");
	property p_step; $changed(duty_o) |->
		(duty_o - $past(duty_o)) inside {4'h0_001, 4'h0_00F}; endproperty
	a_step: assert property (p_step) else $error("duty step");
	// idle buttons long enough must leave the setting alone
	property p_idle; !(|user_input_bus_i)[*8] ##1 !(|user_input_bus_i)[*8] |-> $stable(duty_o);
	endproperty
	a_idle: assert property (p_idle) else $error("duty moved");
	property p_sat; $past(duty_o) == 4'h0_000 |-> duty_o <= 4'h0_001; endproperty
	a_sat: assert property (p_sat) else $error("duty wrap");
	c_top: cover property (duty_o == DUTY_MAX);
	c_dn: cover property ($fell(duty_o[0]));
	c_rise: cover property ($rose(pwm_o));
endmodule
bind bapwm_top bapwm_checker u_bapwm_checker(.*);

// File: tb/bapwm_btn_model.sv
// button pair model: steady contacts or chatter
// assumes the bench sets hold and chatter after clock edges
module bapwm_btn_model
	import bapwm_pkg::*;
(
	input  wire logic       mclk_i,
	input  wire bapwm_btn_t hold_i,
	input  wire logic       chatter_i,
	output bapwm_btn_t      btn_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic t_q = 1'b0;
	// chatter opens held contacts every other cycle, like a bouncing switch
	always_ff @(posedge mclk_i) begin
		t_q <= ~t_q;
		btn_o <= chatter_i ? hold_i & {2{t_q}} : hold_i;
	end
endmodule

// File: tb/tb_top.sv
// bench: presses, chatter, limits
// assumes DEB_TICK 4, so a press settles well within 40 cycles
module tb_top
	import bapwm_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic       mclk_i = 0, rst_n_i = 0, pwm_o, ch = 0;
	logic [3:0] duty_o;
	bapwm_btn_t hb = 0, b;
	int         num_errors = 0, check_count = 0, cyc = 0;
	always #4 mclk_i = ~mclk_i;
	bapwm_btn_model u_bapwm_btn_model(.mclk_i, .hold_i(hb), .chatter_i(ch), .btn_o(b));
	bapwm_top #(.DEB_TICK(4)) u_bapwm_top(.mclk_i, .rst_n_i, .user_input_bus_i(b), .pwm_o,
		.duty_o);
	task chk(input logic [3:0] g, e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %0t %h %h", $time, g, e);
		end
	endtask
	task hi(input logic [3:0] d);
		logic [3:0] n;
		n = 0;
		repeat (10) @(negedge mclk_i) n += 4'(pwm_o);
		chk(n, d);
	endtask
	task push(input bapwm_btn_t v, input logic c);
		@(posedge mclk_i) hb <= v;
		ch <= c;
		repeat (6) @(posedge mclk_i);
		ch <= 0;
		repeat (40) @(posedge mclk_i);
		hb <= 0;
		repeat (40) @(posedge mclk_i);
	endtask
	task t_rst;
		chk(duty_o, 0);
		push(1, 0);
		chk(duty_o, 0);
		hi(0);
	endtask
	task t_up;
		for (int i = 1; i < 10; i++) begin
			push(2, 0);
			chk(duty_o, 4'(i));
			hi(4'(i));
		end
		push(2, 0);
		chk(duty_o, 9);
	endtask
	task t_chat;
		push(1, 1);
		chk(duty_o, 8);
		hi(8);
		// both buttons in one sample must leave the setting alone
		push(3, 0);
		chk(duty_o, 8);
	endtask
	// reset in mid-run must bring a nonzero setting back to zero
	task t_mid;
		@(posedge mclk_i) rst_n_i <= 0;
		repeat (4) @(posedge mclk_i);
		chk(duty_o, 0);
		hi(0);
		@(posedge mclk_i) rst_n_i <= 1;
		push(2, 0);
		chk(duty_o, 1);
	endtask
	task test_done;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	always @(posedge mclk_i) if (++cyc == 5000) begin
		num_errors++;
		test_done;
	end
	initial begin
		repeat (10) @(posedge mclk_i);
		rst_n_i <= 1;
		t_rst;
		t_up;
		t_chat;
		t_mid;
		test_done;
	end
endmodule
